// [hdl/tcc_timer.sv]
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/100ps
module tcc_timer
    import tcc_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins
    input  wire logic        external_timer_clock_pin,
    input  wire logic [3:0]  channel_pin_in,
    output logic [3:0]       channel_pin_out,
    output logic [3:0]       channel_pin_oe,
    output logic             ext_clock_taken
);
    logic [7:0]  status_q;
    logic [15:0] count_q;
    logic [15:0] modulo_q;
    logic [7:0]  mod_high_hold_q;
    logic        mod_block_q;
    logic [7:0]  cnt_low_latch_q;
    logic        cnt_latched_q;
    logic        tick;
    logic        at_modulo;
    logic        overflow;
    logic        acc;
    logic        wr;
    logic        rd;
    logic        counter_clear;
    logic        hit;
    logic [31:0] rdata_d;
    logic [3:0]  ch_ctrl_wr;
    logic [3:0]  ch_high_wr;
    logic [3:0]  ch_low_wr;
    logic [3:0]  ch_high_rd;
    logic [3:0]  ch_low_rd;
    logic [7:0]  ch_ctrl  [TCC_CHANNELS];
    logic [15:0] ch_value [TCC_CHANNELS];

    assign acc    = psel && penable;
    assign wr     = acc && pwrite;
    assign rd     = acc && !pwrite;
    assign pready = 1'b1;
    assign counter_clear = wr && paddr == TCC_ADDR_STATUS && pwdata[TCC_ST_CLEAR_BIT];

    tcc_prescaler u_prescaler (
        .pclk             (pclk),
        .presetn          (presetn),
        .prescaler_select (status_q[TCC_ST_PS_LSB +: 3]),
        .counter_halt     (status_q[TCC_ST_HALT_BIT]),
        .counter_clear    (counter_clear),
        .ext_clock_in     (external_timer_clock_pin),
        .tick             (tick)
    );

    assign at_modulo = count_q == modulo_q;
    assign overflow  = tick && at_modulo;
    assign ext_clock_taken = status_q[TCC_ST_PS_LSB +: 3] == TCC_PS_EXTERNAL;

    // One counter; reads never touch it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_q <= 16'h0000;
        else if (counter_clear)
            count_q <= 16'h0000;
        else if (tick)
            count_q <= at_modulo ? 16'h0000 : count_q + 16'h0001;
    end

    // Overflow flag set wins over clear; held off while modulo write pending
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status_q <= TCC_STATUS_RESET;
        else
        begin
            if (wr && paddr == TCC_ADDR_STATUS)
            begin
                status_q[6:0] <= {pwdata[6:5], 2'b00, pwdata[2:0]};
                if (!pwdata[TCC_ST_OVF_BIT])
                    status_q[TCC_ST_OVF_BIT] <= 1'b0;
            end
            if (overflow && !mod_block_q)
                status_q[TCC_ST_OVF_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            modulo_q        <= TCC_MOD_RESET;
            mod_high_hold_q <= TCC_MOD_RESET[15:8];
            mod_block_q     <= 1'b0;
        end
        else if (wr && paddr == TCC_ADDR_MOD_HIGH)
        begin
            mod_high_hold_q <= pwdata[7:0];
            mod_block_q     <= 1'b1;
        end
        else if (wr && paddr == TCC_ADDR_MOD_LOW)
        begin
            modulo_q    <= {mod_high_hold_q, pwdata[7:0]};
            mod_block_q <= 1'b0;
        end
    end

    // High read latches low byte so a 16-bit read is coherent
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_low_latch_q <= 8'h00;
            cnt_latched_q   <= 1'b0;
        end
        else if (rd && paddr == TCC_ADDR_CNT_HIGH && !cnt_latched_q)
        begin
            cnt_low_latch_q <= count_q[7:0];
            cnt_latched_q   <= 1'b1;
        end
        else if (rd && paddr == TCC_ADDR_CNT_LOW)
            cnt_latched_q <= 1'b0;
    end

    genvar g;
    generate
        for (g = 0; g < TCC_CHANNELS; g++)
        begin : g_ch
            localparam logic [7:0] BASE = TCC_ADDR_CH_BASE + 8'(g) * TCC_CH_STRIDE;
            assign ch_ctrl_wr[g] = wr && paddr == BASE + TCC_CH_CTRL_OFF;
            assign ch_high_wr[g] = wr && paddr == BASE + TCC_CH_HIGH_OFF;
            assign ch_low_wr[g]  = wr && paddr == BASE + TCC_CH_LOW_OFF;
            assign ch_high_rd[g] = rd && paddr == BASE + TCC_CH_HIGH_OFF;
            assign ch_low_rd[g]  = rd && paddr == BASE + TCC_CH_LOW_OFF;

            tcc_channel u_ch (
                .pclk     (pclk),
                .presetn  (presetn),
                .count    (count_q),
                .tick     (tick),
                .overflow (overflow),
                .ctrl_wr  (ch_ctrl_wr[g]),
                .high_wr  (ch_high_wr[g]),
                .low_wr   (ch_low_wr[g]),
                .high_rd  (ch_high_rd[g]),
                .low_rd   (ch_low_rd[g]),
                .wdata    (pwdata[7:0]),
                .pin_in   (channel_pin_in[g]),
                .pin_out  (channel_pin_out[g]),
                .pin_oe   (channel_pin_oe[g]),
                .ctrl_q   (ch_ctrl[g]),
                .value_q  (ch_value[g])
            );
        end
    endgenerate

    // Read mux; unmapped addresses answer with an error
    always_comb
    begin
        rdata_d = TCC_ERR_NONE;
        hit     = 1'b1;
        case (paddr)
            TCC_ADDR_STATUS:   rdata_d = {24'h00_0000, status_q};
            TCC_ADDR_CNT_HIGH: rdata_d = {24'h00_0000, count_q[15:8]};
            TCC_ADDR_CNT_LOW:  rdata_d = {24'h00_0000, cnt_latched_q ? cnt_low_latch_q : count_q[7:0]};
            TCC_ADDR_MOD_HIGH: rdata_d = {24'h00_0000, modulo_q[15:8]};
            TCC_ADDR_MOD_LOW:  rdata_d = {24'h00_0000, modulo_q[7:0]};
            default:
            begin
                hit = 1'b0;
                for (int i = 0; i < TCC_CHANNELS; i++)
                begin
                    if (paddr == TCC_ADDR_CH_BASE + 8'(i) * TCC_CH_STRIDE + TCC_CH_CTRL_OFF)
                    begin
                        rdata_d = {24'h00_0000, ch_ctrl[i]};
                        hit     = 1'b1;
                    end
                    if (paddr == TCC_ADDR_CH_BASE + 8'(i) * TCC_CH_STRIDE + TCC_CH_HIGH_OFF)
                    begin
                        rdata_d = {24'h00_0000, ch_value[i][15:8]};
                        hit     = 1'b1;
                    end
                    if (paddr == TCC_ADDR_CH_BASE + 8'(i) * TCC_CH_STRIDE + TCC_CH_LOW_OFF)
                    begin
                        rdata_d = {24'h00_0000, ch_value[i][7:0]};
                        hit     = 1'b1;
                    end
                end
            end
        endcase
    end

    assign prdata  = rdata_d;
    assign pslverr = acc && !hit;
endmodule

// [hdl/tcc_pkg.sv]
// Functional notes
// - Channel value holds capture or compare value
// - Channel values undefined after reset
// - High byte read blocks captures until low
// - High byte write blocks compares until low
// - One 16-bit counter, free or modulo
// - Modulo value from high and low bytes
// - Counter reads never disturb counting
// - Each channel independently capture or compare
// - Prescaler select picks counter clock source
// - Capture on rising, falling or either edge
// - Compare match sets, clears or toggles pin
// - Buffered and unbuffered PWM outputs
// - Channel pin may toggle on overflow
// - Software halt and clear of counter
// - Pins used only when function enabled
// - At modulo set overflow, restart from zero
// - Codes divide by 1..64, 111 external
// - Channel flag on edge or compare match
package tcc_pkg;
    localparam logic [7:0] TCC_ADDR_STATUS   = 8'h00;
    localparam logic [7:0] TCC_ADDR_CNT_HIGH = 8'h04;
    localparam logic [7:0] TCC_ADDR_CNT_LOW  = 8'h08;
    localparam logic [7:0] TCC_ADDR_MOD_HIGH = 8'h0C;
    localparam logic [7:0] TCC_ADDR_MOD_LOW  = 8'h10;
    localparam logic [7:0] TCC_ADDR_CH_BASE  = 8'h20;
    localparam logic [7:0] TCC_CH_STRIDE     = 8'h0C;
    localparam logic [7:0] TCC_CH_CTRL_OFF   = 8'h00;
    localparam logic [7:0] TCC_CH_HIGH_OFF   = 8'h04;
    localparam logic [7:0] TCC_CH_LOW_OFF    = 8'h08;
    localparam int         TCC_CHANNELS      = 4;
    // Status register fields
    localparam int TCC_ST_OVF_BIT   = 7;
    localparam int TCC_ST_HALT_BIT  = 5;
    localparam int TCC_ST_CLEAR_BIT = 4;
    localparam int TCC_ST_PS_LSB    = 0;
    // Channel control fields
    localparam int TCC_CC_FLAG_BIT  = 7;
    localparam int TCC_CC_MSB_BIT   = 5;
    localparam int TCC_CC_MSA_BIT   = 4;
    localparam int TCC_CC_ELSB_BIT  = 3;
    localparam int TCC_CC_ELSA_BIT  = 2;
    localparam int TCC_CC_TOV_BIT   = 1;
    localparam int TCC_CC_MAX_BIT   = 0;
    localparam logic [7:0]  TCC_STATUS_RESET = 8'h20;
    localparam logic [7:0]  TCC_CTRL_RESET   = 8'h00;
    localparam logic [15:0] TCC_MOD_RESET    = 16'hFFFF;
    localparam logic [2:0]  TCC_PS_EXTERNAL  = 3'h7;
    localparam logic [31:0] TCC_ERR_NONE     = 32'h0000_0000;
endpackage

// [hdl/tcc_prescaler.sv]
`timescale 1ns/100ps
module tcc_prescaler
    import tcc_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control
    input  wire logic [2:0] prescaler_select,
    input  wire logic       counter_halt,
    input  wire logic       counter_clear,
    input  wire logic       ext_clock_in,
    // Tick out
    output logic            tick
);
    logic [5:0] div_q;
    logic       ext_prev_q;
    logic [6:0] div_tick;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_q <= 6'h00;
        else if (counter_clear)
            div_q <= 6'h00;
        else if (!counter_halt)
            div_q <= div_q + 6'h01;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ext_prev_q <= 1'b0;
        else
            ext_prev_q <= ext_clock_in;
    end

    // Divide by 2^n: tick when low n bits all ones
    assign div_tick[0] = 1'b1;
    for (genvar i = 1; i < 7; i++)
    begin : g_div
        assign div_tick[i] = &div_q[i-1:0];
    end

    // External pin is a level; its rising edge is one counter tick. Must stay well below pclk
    always_comb
    begin
        if (counter_halt)
            tick = 1'b0;
        else if (prescaler_select == TCC_PS_EXTERNAL)
            tick = ext_clock_in & ~ext_prev_q;
        else
            tick = div_tick[prescaler_select];
    end
endmodule

// [hdl/tcc_channel.sv]
`timescale 1ns/100ps
module tcc_channel
    import tcc_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Timebase
    input  wire logic [15:0] count,
    input  wire logic        tick,
    input  wire logic        overflow,
    // Register access
    input  wire logic        ctrl_wr,
    input  wire logic        high_wr,
    input  wire logic        low_wr,
    input  wire logic        high_rd,
    input  wire logic        low_rd,
    input  wire logic [7:0]  wdata,
    // Pin
    input  wire logic        pin_in,
    output logic             pin_out,
    output logic             pin_oe,
    // Readback
    output logic [7:0]       ctrl_q,
    output logic [15:0]      value_q
);
    logic        flag_q;
    logic [6:0]  mode_q;
    logic        pin_q;
    logic        pin_prev_q;
    logic        cap_block_q;
    logic        cmp_block_q;
    logic [15:0] active_q;
    logic [15:0] value_d;
    logic        ms_b;
    logic        ms_a;
    logic [1:0]  els;
    logic        capture_mode;
    logic        rise;
    logic        fall;
    logic        cap_event;
    logic        match;

    assign ms_b         = ctrl_q[TCC_CC_MSB_BIT];
    assign ms_a         = ctrl_q[TCC_CC_MSA_BIT];
    assign els          = ctrl_q[TCC_CC_ELSB_BIT:TCC_CC_ELSA_BIT];
    assign capture_mode = !ms_b && !ms_a;
    assign rise         = pin_in & ~pin_prev_q;
    assign fall         = ~pin_in & pin_prev_q;
    assign cap_event    = capture_mode && ((els[0] && rise) || (els[1] && fall));
    assign match        = !capture_mode && els != 2'b00 && tick && count == active_q
                          && !cmp_block_q;

    // Flag kept apart from the mode bits so software can read it but never set it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_q <= TCC_CTRL_RESET[6:0];
        else if (ctrl_wr)
            mode_q <= wdata[6:0];
    end

    assign ctrl_q = {flag_q, mode_q};

    // Flag: set wins over a software clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flag_q <= 1'b0;
        else if ((cap_event && !cap_block_q) || match)
            flag_q <= 1'b1;
        else if (ctrl_wr && !wdata[TCC_CC_FLAG_BIT])
            flag_q <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_prev_q <= 1'b0;
        else
            pin_prev_q <= pin_in;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cap_block_q <= 1'b0;
        else if (!capture_mode || low_rd)
            cap_block_q <= 1'b0;
        else if (high_rd)
            cap_block_q <= 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cmp_block_q <= 1'b0;
        else if (capture_mode || low_wr)
            cmp_block_q <= 1'b0;
        else if (high_wr)
            cmp_block_q <= 1'b1;
    end

    // Value is never reset; its content after reset is undefined
    always_comb
    begin
        value_d = value_q;
        if (high_wr)
            value_d[15:8] = wdata;
        if (low_wr)
            value_d[7:0] = wdata;
        if (cap_event && !cap_block_q)
            value_d = count;
    end

    always_ff @(posedge pclk)
    begin
        value_q <= value_d;
    end

    // Buffered mode loads the new compare value only at overflow; unbuffered loads at once
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            active_q <= 16'h0000;
        else if (!ms_b || overflow)
            active_q <= value_q;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_q <= 1'b0;
        else if (els == 2'b00)
            pin_q <= ms_a ? 1'b0 : 1'b1;
        else if (capture_mode)
            pin_q <= pin_q;
        else if (ctrl_q[TCC_CC_MAX_BIT] && !ctrl_q[TCC_CC_TOV_BIT])
            pin_q <= 1'b1;
        else if (overflow && ctrl_q[TCC_CC_TOV_BIT])
            pin_q <= ~pin_q;
        else if (match)
        begin
            case (els)
                2'b01:   pin_q <= ~pin_q;
                2'b10:   pin_q <= 1'b0;
                2'b11:   pin_q <= 1'b1;
                default: pin_q <= pin_q;
            endcase
        end
    end

    assign pin_out = pin_q;
    assign pin_oe  = !capture_mode && els != 2'b00;
endmodule

// [verification/tcc_timer_asserts.sv]
`timescale 1ns/100ps
module tcc_timer_asserts
    import tcc_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins
    input wire logic        external_timer_clock_pin,
    input wire logic [3:0]  channel_pin_in,
    input wire logic [3:0]  channel_pin_out,
    input wire logic [3:0]  channel_pin_oe,
    input wire logic        ext_clock_taken
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       acc;
    logic       hit;
    logic [2:0] ps_q;
    logic       halt_q;
    assign acc = psel & penable;
    assign hit = (paddr[1:0] == 2'h0) && ((paddr <= 8'h10) || ((paddr >= 8'h20) && (paddr <= 8'h4C)));
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ps_q   <= 3'h0;
            halt_q <= 1'b1;
        end
        else if (acc && pwrite && (paddr == TCC_ADDR_STATUS))
        begin
            ps_q   <= pwdata[2:0];
            halt_q <= pwdata[TCC_ST_HALT_BIT];
        end
    end
    zero_wait_a: assert property (acc |-> pready)
        else $error("access not answered at once");
    unmapped_err_a: assert property (acc |-> (pslverr == !hit))
        else $error("slave error does not match address map");
    unmapped_zero_a: assert property (acc && !pwrite && !hit |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    ext_select_a: assert property (ext_clock_taken == (ps_q == TCC_PS_EXTERNAL))
        else $error("clock pin taken without select");
    status_readback_a: assert property (acc && !pwrite && paddr == TCC_ADDR_STATUS |->
        prdata[5] == halt_q && prdata[2:0] == ps_q && !prdata[4])
        else $error("status readback wrong");
    for (genvar g = 0; g < TCC_CHANNELS; g++)
    begin : g_ch
        localparam logic [7:0] CA = TCC_ADDR_CH_BASE + TCC_CH_STRIDE * 8'(g);
        logic [5:0] ctl_q;
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                ctl_q <= 6'h00;
            else if (acc && pwrite && (paddr == CA))
                ctl_q <= pwdata[5:0];
        end
        pin_drive_a: assert property (channel_pin_oe[g] == ((|ctl_q[5:4]) && (|ctl_q[3:2])))
            else $error("pin enable does not match channel mode");
        ctrl_readback_a: assert property (acc && !pwrite && paddr == CA |-> prdata[5:0] == ctl_q)
            else $error("channel control readback wrong");
    end
    cover property (acc && pwrite && paddr == TCC_ADDR_STATUS && pwdata[2:0] == TCC_PS_EXTERNAL);
    cover property ($rose(channel_pin_out[1]));
    cover property (acc && pslverr);
endmodule

bind tcc_timer tcc_timer_asserts tcc_timer_asserts_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_timer_clock_pin(external_timer_clock_pin), .channel_pin_in(channel_pin_in),
    .channel_pin_out(channel_pin_out), .channel_pin_oe(channel_pin_oe), .ext_clock_taken(ext_clock_taken));

// [verification/tcc_pin_model.sv]
`timescale 1ns/100ps
module tcc_pin_model (
    // Clock
    input wire logic  pclk,
    // Far side levels
    output logic [3:0] pin_lvl,
    output logic       ext_clk
);
    initial
    begin
        pin_lvl = 4'h0;
        ext_clk = 1'b0;
    end
    task automatic set_pin(input int ch, input logic v);
        @(posedge pclk);
        pin_lvl[ch] <= v;
    endtask
    // Period of 50 bus clocks keeps the pin at 4 MHz; idles low between bursts
    task automatic ext_pulses(input int n);
        repeat (n)
        begin
            @(posedge pclk);
            ext_clk <= 1'b1;
            repeat (25) @(posedge pclk);
            ext_clk <= 1'b0;
            repeat (24) @(posedge pclk);
        end
    endtask
endmodule

// [verification/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
    import tcc_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_clk;
    logic [3:0]  pin_lvl;
    logic [3:0]  pin_in;
    logic [3:0]  pin_out;
    logic [3:0]  pin_oe;
    logic        ext_taken;
    logic [31:0] rdv;
    logic        erv;
    logic        lv;
    logic [15:0] cv;
    logic [15:0] c0;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          acts [3] = '{1, 3, 2};
    always #2.5 pclk = ~pclk;
    // Wire level: the timer wins only while it drives the pin
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_lvl);
    tcc_timer tcc_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_timer_clock_pin(ext_clk), .channel_pin_in(pin_in),
        .channel_pin_out(pin_out), .channel_pin_oe(pin_oe), .ext_clock_taken(ext_taken));
    tcc_pin_model pm_i (.pclk(pclk), .pin_lvl(pin_lvl), .ext_clk(ext_clk));
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            summarize();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next call never reassigns psel in this time step
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    function automatic logic [7:0] ca(input int n, input logic [7:0] o);
        return TCC_ADDR_CH_BASE + TCC_CH_STRIDE * 8'(n) + o;
    endfunction
    // High then low, so the low byte is the one latched with the high read
    task automatic rd16(input logic [7:0] ah, input logic [7:0] al);
        rd(ah);
        cv[15:8] = rdv[7:0];
        rd(al);
        cv[7:0] = rdv[7:0];
    endtask
    task automatic pk();
        @(negedge pclk);
        lv = pin_out[1];
        @(posedge pclk);
    endtask
    task automatic pulse0();
        pm_i.set_pin(0, 1'b1);
        wt(4);
        pm_i.set_pin(0, 1'b0);
        wt(4);
    endtask
    initial
    begin
        wt(3);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(TCC_ADDR_STATUS);
        chk(rdv, 32'(TCC_STATUS_RESET));
        rd(8'h14);
        chk(32'(erv), 32'h1);
        $display("reset and map test done");
        wr(TCC_ADDR_STATUS, 32'h00);
        wt(40);
        wr(TCC_ADDR_STATUS, 32'h20);
        rd16(TCC_ADDR_CNT_HIGH, TCC_ADDR_CNT_LOW);
        c0 = cv;
        wt(20);
        rd16(TCC_ADDR_CNT_HIGH, TCC_ADDR_CNT_LOW);
        chk(32'(cv), 32'(c0));
        chk(32'(cv != 16'h0000), 32'h1);
        wr(TCC_ADDR_STATUS, 32'h30);
        rd16(TCC_ADDR_CNT_HIGH, TCC_ADDR_CNT_LOW);
        chk(32'(cv), 32'h0);
        $display("halt and clear test done");
        for (int k = 0; k < 8; k++)
        begin
            wr(TCC_ADDR_STATUS, 32'h30 | k);
            wr(TCC_ADDR_STATUS, 32'(k));
            chk(32'(ext_taken), 32'(k == 7));
            if (k == 7)
                pm_i.ext_pulses(5);
            else
                wt(128);
            wr(TCC_ADDR_STATUS, 32'h20 | k);
            rd16(TCC_ADDR_CNT_HIGH, TCC_ADDR_CNT_LOW);
            c0 = (k == 7) ? 16'h0005 : 16'(130 >> k);
            chk(32'(cv + 16'h0002 - c0 <= 16'h0004), 32'h1);
        end
        $display("prescaler test done");
        for (int e = 1; e < 4; e++)
        begin
            wr(ca(0, TCC_CH_CTRL_OFF), 32'(e << 2));
            pm_i.set_pin(0, 1'b1);
            wt(4);
            rd(ca(0, TCC_CH_CTRL_OFF));
            chk(32'(rdv[7]), 32'(e & 1));
            wr(ca(0, TCC_CH_CTRL_OFF), 32'(e << 2));
            pm_i.set_pin(0, 1'b0);
            wt(4);
            rd(ca(0, TCC_CH_CTRL_OFF));
            chk(32'(rdv[7]), 32'(e >> 1));
        end
        chk(32'(pin_oe[0]), 32'h0);
        wr(ca(0, TCC_CH_CTRL_OFF), 32'h04);
        wr(TCC_ADDR_STATUS, 32'h30);
        pulse0();
        wr(TCC_ADDR_STATUS, 32'h00);
        wt(30);
        wr(TCC_ADDR_STATUS, 32'h20);
        rd16(TCC_ADDR_CNT_HIGH, TCC_ADDR_CNT_LOW);
        c0 = cv;
        rd(ca(0, TCC_CH_HIGH_OFF));
        chk(rdv, 32'h0);
        pulse0();
        rd(ca(0, TCC_CH_LOW_OFF));
        chk(rdv, 32'h0);
        pulse0();
        rd16(ca(0, TCC_CH_HIGH_OFF), ca(0, TCC_CH_LOW_OFF));
        chk(32'(cv), 32'(c0));
        $display("capture test done");
        wr(TCC_ADDR_STATUS, 32'h30);
        wr(TCC_ADDR_MOD_HIGH, 32'h00);
        wr(TCC_ADDR_MOD_LOW, 32'h09);
        wr(TCC_ADDR_STATUS, 32'h00);
        wt(40);
        rd(TCC_ADDR_STATUS);
        chk(32'(rdv[7]), 32'h1);
        rd16(TCC_ADDR_CNT_HIGH, TCC_ADDR_CNT_LOW);
        chk(32'(cv <= 16'h0009), 32'h1);
        $display("modulo test done");
        for (int i = 0; i < 3; i++)
        begin
            wr(ca(1, TCC_CH_CTRL_OFF), 32'h10 | (acts[i] << 2));
            wr(ca(1, TCC_CH_HIGH_OFF), 32'h00);
            wr(ca(1, TCC_CH_LOW_OFF), 32'h05);
            wt(30);
            pk();
            c0[0] = lv;
            wt(9);
            pk();
            if (acts[i] == 1)
                chk(32'(lv != c0[0]), 32'h1);
            else
                chk(32'(lv), 32'(acts[i] == 3));
        end
        rd(ca(1, TCC_CH_CTRL_OFF));
        chk(32'(rdv[7]), 32'h1);
        chk(32'(pin_oe[1]), 32'h1);
        wr(ca(1, TCC_CH_HIGH_OFF), 32'h00);
        wr(ca(1, TCC_CH_CTRL_OFF), 32'h1C);
        wt(30);
        pk();
        chk(32'(lv), 32'h0);
        wr(ca(1, TCC_CH_LOW_OFF), 32'h05);
        wt(30);
        pk();
        chk(32'(lv), 32'h1);
        wr(ca(1, TCC_CH_CTRL_OFF), 32'h19);
        wt(30);
        pk();
        chk(32'(lv), 32'h1);
        wr(ca(1, TCC_CH_HIGH_OFF), 32'h01);
        wr(ca(1, TCC_CH_LOW_OFF), 32'h00);
        wr(ca(1, TCC_CH_CTRL_OFF), 32'h16);
        wt(30);
        pk();
        c0[0] = lv;
        wt(9);
        pk();
        chk(32'(lv != c0[0]), 32'h1);
        $display("compare test done");
        summarize();
    end
endmodule
